// >>> rtl/bit_call_exec_map.svh
`ifndef BIT_CALL_EXEC_MAP_SVH
`define BIT_CALL_EXEC_MAP_SVH

// Register byte offsets
`define OFS_COMMAND 8'h00
`define OFS_OPERAND 8'h04
`define OFS_STATUS 8'h08
`define OFS_ACC 8'h0c
`define OFS_STATUS_WORD 8'h10
`define OFS_PC 8'h14
`define OFS_SP 8'h18
`define OFS_CLOCK_CONTROL 8'h1c
`define OFS_MEM_ADDR 8'h20
`define OFS_MEM_DATA 8'h24
`define OFS_HL 8'h28

// Command word fields
`define CMD_OP_LSB 0
`define CMD_BIT_LSB 4
`define CMD_KIND_LSB 8

// Status word bit positions
`define SW_IE 7
`define SW_Z 6
`define SW_AC 4
`define SW_CY 0

// Reset values
`define RST_STATUS_WORD 8'h02
`define RST_SP 16'hfee0
`define RST_PC 16'h0000
`define RST_CLOCK_CONTROL 3'h0

// Fixed addresses
`define BRK_VEC_LO 16'h003e
`define BRK_VEC_HI 16'h003f
`define FAST_RAM_LO 16'hfe20
`define FAST_RAM_HI 16'hff1f
`define SFR_PAGE 8'hff

// Instruction clock counts
`define CYC_BIT_SADDR_FAST 4'h6
`define CYC_BIT_SLOW 4'h7
`define CYC_BIT_ACC 4'h4
`define CYC_SET_SADDR_FAST 4'h4
`define CYC_SET_SADDR_SLOW 4'h6
`define CYC_SET_HL_FAST 4'h6
`define CYC_STORE_SLOW 4'h8
`define CYC_ADJUST 4'h4
`define CYC_CALL 4'h7
`define CYC_FIXED_AREA_CALL 4'h5
`define CYC_TABLE_CALL 4'h6
`define CYC_BRK 4'h6
`define CYC_RET 4'h6

`endif

// >>> rtl/bit_call_exec_pkg.sv
package bit_call_exec_pkg;
  typedef enum logic [3:0] {
    OP_AND   = 4'h0,
    OP_OR    = 4'h1,
    OP_XOR   = 4'h2,
    OP_MOVCY = 4'h3,
    OP_MOVBIT = 4'h4,
    OP_SET   = 4'h5,
    OP_CLR   = 4'h6,
    OP_ADJ   = 4'h7,
    OP_CALL  = 4'h8,
    OP_FIXED_AREA_CALL = 4'h9,
    OP_TABLE_CALL = 4'ha,
    OP_BRK   = 4'hb,
    OP_RET   = 4'hc,
    OP_INTERRUPT_RETURN  = 4'hd,
    OP_BREAK_RETURN  = 4'he
  } op_t;

  typedef enum logic [2:0] {
    K_SADDR = 3'h0,
    K_SFR   = 3'h1,
    K_ACC   = 3'h2,
    K_SW    = 3'h3,
    K_HL    = 3'h4
  } kind_t;
endpackage

// >>> rtl/cpu_clock_enable.sv
`timescale 1ns/100ps
// One-cycle enable every 2**sel clocks
module cpu_clock_enable (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [6:0] count;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << sel) - 8'h01);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // cpu_clock_enable

// >>> rtl/bit_call_exec.sv
`timescale 1ns/100ps
`include "bit_call_exec_map.svh"
module bit_call_exec
  import bit_call_exec_pkg::*;
#(
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int DEPTH = 1 << AW;

  logic [7:0] mem [DEPTH];
  logic [7:0] acc;
  logic [7:0] statusWord;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] hl;
  logic [2:0] clockControl;
  logic [15:0] memAddr;
  logic [15:0] operand;
  op_t curOp;
  kind_t curKind;
  logic [2:0] curBit;
  logic busy;
  logic [3:0] remain;
  logic [3:0] lastCycles;
  logic tick;
  logic [7:0] wAddr;
  logic awHeld;
  logic wHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrDo;
  logic wrOk;
  logic startCmd;
  logic commit;
  logic [31:0] next_rdata;
  logic next_rok;

  function automatic logic [AW-1:0] idx(input logic [15:0] a);
    return a[AW-1:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic isFast(input logic [15:0] a);
    return (a >= `FAST_RAM_LO) && (a <= `FAST_RAM_HI);
  endfunction

  // Operand address for memory-based bit kinds
  function automatic logic [15:0] bitAddr(input kind_t k,
      input logic [15:0] opnd, input logic [15:0] h);
    case (k)
      K_SFR: return {`SFR_PAGE, opnd[7:0]};
      K_HL: return h;
      default: return opnd;
    endcase
  endfunction

  // Cycle count per op and operand area
  function automatic logic [3:0] cycles(input op_t o, input kind_t k,
      input logic fast);
    case (o)
      OP_AND, OP_OR, OP_XOR, OP_MOVCY: begin
        case (k)
          K_ACC: return `CYC_BIT_ACC;
          K_SADDR, K_HL: return fast ? `CYC_BIT_SADDR_FAST : `CYC_BIT_SLOW;
          default: return `CYC_BIT_SLOW;
        endcase
      end
      OP_MOVBIT: begin
        case (k)
          K_ACC: return `CYC_BIT_ACC;
          K_SADDR, K_HL: return fast ? `CYC_BIT_SADDR_FAST : `CYC_STORE_SLOW;
          default: return `CYC_STORE_SLOW;
        endcase
      end
      OP_SET, OP_CLR: begin
        case (k)
          K_ACC: return `CYC_BIT_ACC;
          K_SADDR: return fast ? `CYC_SET_SADDR_FAST : `CYC_SET_SADDR_SLOW;
          K_SW: return `CYC_SET_SADDR_SLOW;
          K_HL: return fast ? `CYC_SET_HL_FAST : `CYC_STORE_SLOW;
          default: return `CYC_STORE_SLOW;
        endcase
      end
      OP_ADJ: return `CYC_ADJUST;
      OP_CALL: return `CYC_CALL;
      OP_FIXED_AREA_CALL: return `CYC_FIXED_AREA_CALL;
      OP_TABLE_CALL: return `CYC_TABLE_CALL;
      OP_BRK: return `CYC_BRK;
      default: return `CYC_RET;
    endcase
  endfunction

  cpu_clock_enable u_clock_enable (
    .clk(clk),
    .rstn(rstn),
    .sel(clockControl),
    .tick(tick)
  );

  // Write channel handshake, either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        wAddr <= awaddr;
        awHeld <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
        wHeld <= 1'b1;
        wready <= 1'b0;
      end
      if (wrDo) begin
        bvalid <= 1'b1;
        bresp <= wrOk ? 2'b00 : 2'b10;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  assign wrDo = awHeld && wHeld && !bvalid;

  // State registers are locked while an instruction runs
  always_comb begin
    case ({wAddr[7:2], 2'b00})
      `OFS_OPERAND, `OFS_ACC, `OFS_STATUS_WORD, `OFS_PC, `OFS_SP,
      `OFS_HL, `OFS_MEM_DATA, `OFS_CLOCK_CONTROL: wrOk = !busy;
      `OFS_COMMAND: wrOk = !busy && (wData[3:0] <= 4'he) && wStrb[0]
        && (wData[10:8] <= 3'h4);
      `OFS_MEM_ADDR: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  assign startCmd = wrDo && wrOk && ({wAddr[7:2], 2'b00} == `OFS_COMMAND);
  assign commit = busy && tick && (remain == 4'h1);

  // Instruction latch and clock counting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      remain <= 4'h0;
      lastCycles <= 4'h0;
      curOp <= OP_AND;
      curKind <= K_SADDR;
      curBit <= 3'h0;
    end else if (startCmd) begin
      busy <= 1'b1;
      curOp <= op_t'(wData[`CMD_OP_LSB +: 4]);
      curKind <= kind_t'(wData[`CMD_KIND_LSB +: 3]);
      curBit <= wData[`CMD_BIT_LSB +: 3];
      // Fast when the operand address lies in high-speed RAM
      remain <= cycles(op_t'(wData[`CMD_OP_LSB +: 4]),
        kind_t'(wData[`CMD_KIND_LSB +: 3]),
        isFast(bitAddr(kind_t'(wData[`CMD_KIND_LSB +: 3]), operand, hl))
      );
      lastCycles <= 4'h0;
    end else if (busy && tick) begin
      remain <= remain - 4'h1;
      lastCycles <= lastCycles + 4'h1;
      if (remain == 4'h1) begin
        busy <= 1'b0;
      end
    end
  end

  // Execution results, applied at the last instruction clock
  logic [15:0] tAddr;
  logic [7:0] tByte;
  logic bitVal;
  logic [7:0] next_acc;
  logic [7:0] next_sw;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [2:0] we;
  logic [15:0] wa [3];
  logic [7:0] wd [3];
  logic [15:0] ret;
  logic lowAdj;
  logic highAdj;

  always_comb begin
    tAddr = bitAddr(curKind, operand, hl);
    case (curKind)
      K_ACC: tByte = acc;
      K_SW: tByte = statusWord;
      default: tByte = mem[idx(tAddr)];
    endcase
    bitVal = tByte[curBit];
    next_acc = acc;
    next_sw = statusWord;
    next_pc = pc;
    next_sp = sp;
    we = 3'b000;
    wa[0] = tAddr;
    wa[1] = tAddr;
    wa[2] = tAddr;
    wd[0] = tByte;
    wd[1] = 8'h00;
    wd[2] = 8'h00;
    ret = pc;
    lowAdj = 1'b0;
    highAdj = 1'b0;
    case (curOp)
      OP_AND: next_sw[`SW_CY] = statusWord[`SW_CY] & bitVal;
      OP_OR: next_sw[`SW_CY] = statusWord[`SW_CY] | bitVal;
      OP_XOR: next_sw[`SW_CY] = statusWord[`SW_CY] ^ bitVal;
      OP_MOVCY: next_sw[`SW_CY] = bitVal;
      OP_MOVBIT, OP_SET, OP_CLR: begin
        wd[0][curBit] = (curOp == OP_MOVBIT) ? statusWord[`SW_CY]
          : (curOp == OP_SET);
        case (curKind)
          K_ACC: next_acc = wd[0];
          K_SW: next_sw = wd[0];
          default: we[0] = 1'b1;
        endcase
      end
      OP_ADJ: begin
        lowAdj = statusWord[`SW_AC] || (acc[3:0] > 4'h9);
        highAdj = statusWord[`SW_CY] || (acc > 8'h99);
        next_acc = acc - (lowAdj ? 8'h06 : 8'h00)
          - (highAdj ? 8'h60 : 8'h00);
        next_sw[`SW_CY] = highAdj;
        next_sw[`SW_AC] = lowAdj;
        next_sw[`SW_Z] = (next_acc == 8'h00);
      end
      OP_CALL, OP_FIXED_AREA_CALL, OP_TABLE_CALL: begin
        case (curOp)
          OP_CALL: begin
            ret = pc + 16'h0003;
            next_pc = operand;
          end
          OP_FIXED_AREA_CALL: begin
            ret = pc + 16'h0002;
            next_pc = {5'b00001, operand[10:0]};
          end
          default: begin
            ret = pc + 16'h0001;
            next_pc = {mem[idx(operand + 16'h0001)], mem[idx(operand)]};
          end
        endcase
        we = 3'b011;
        wa[0] = sp - 16'h0001;
        wd[0] = ret[15:8];
        wa[1] = sp - 16'h0002;
        wd[1] = ret[7:0];
        next_sp = sp - 16'h0002;
      end
      OP_BRK: begin
        ret = pc + 16'h0001;
        we = 3'b111;
        wa[0] = sp - 16'h0001;
        wd[0] = statusWord;
        wa[1] = sp - 16'h0002;
        wd[1] = ret[15:8];
        wa[2] = sp - 16'h0003;
        wd[2] = ret[7:0];
        next_pc = {mem[idx(`BRK_VEC_HI)], mem[idx(`BRK_VEC_LO)]};
        next_sp = sp - 16'h0003;
        next_sw[`SW_IE] = 1'b0;
      end
      OP_RET: begin
        next_pc = {mem[idx(sp + 16'h0001)], mem[idx(sp)]};
        next_sp = sp + 16'h0002;
      end
      default: begin
        next_pc = {mem[idx(sp + 16'h0001)], mem[idx(sp)]};
        next_sw = mem[idx(sp + 16'h0002)];
        next_sp = sp + 16'h0003;
      end
    endcase
  end

  // Processor state: bus writes only when idle, commit only when busy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 8'h00;
      statusWord <= `RST_STATUS_WORD;
      pc <= `RST_PC;
      sp <= `RST_SP;
      hl <= 16'h0000;
      operand <= 16'h0000;
      clockControl <= `RST_CLOCK_CONTROL;
    end else if (commit) begin
      acc <= next_acc;
      statusWord <= next_sw;
      pc <= next_pc;
      sp <= next_sp;
    end else if (wrDo && wrOk) begin
      case ({wAddr[7:2], 2'b00})
        `OFS_OPERAND: operand <= 16'(merge({16'h0, operand}, wData, wStrb));
        `OFS_ACC: acc <= 8'(merge({24'h0, acc}, wData, wStrb));
        `OFS_STATUS_WORD: statusWord <= 8'(merge({24'h0, statusWord},
          wData, wStrb));
        `OFS_PC: pc <= 16'(merge({16'h0, pc}, wData, wStrb));
        `OFS_SP: sp <= 16'(merge({16'h0, sp}, wData, wStrb));
        `OFS_HL: hl <= 16'(merge({16'h0, hl}, wData, wStrb));
        `OFS_CLOCK_CONTROL: clockControl <= 3'(merge({29'h0, clockControl},
          wData, wStrb));
        default: ;
      endcase
    end
  end

  // Pointer stays writable during a run, so a commit must not mask it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memAddr <= 16'h0000;
    end else if (wrDo && wrOk && ({wAddr[7:2], 2'b00} == `OFS_MEM_ADDR)) begin
      memAddr <= 16'(merge({16'h0, memAddr}, wData, wStrb));
    end
  end

  // Data memory, no reset; stack frames land here
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < 3; i++) begin
        if (we[i]) begin
          mem[idx(wa[i])] <= wd[i];
        end
      end
    end else if (wrDo && wrOk && wStrb[0]
        && ({wAddr[7:2], 2'b00} == `OFS_MEM_DATA)) begin
      mem[idx(memAddr)] <= wData[7:0];
    end
  end

  // Read path
  always_comb begin
    next_rok = 1'b1;
    case ({araddr[7:2], 2'b00})
      `OFS_COMMAND: next_rdata = {21'h0, curKind, 1'b0, curBit, curOp};
      `OFS_OPERAND: next_rdata = {16'h0, operand};
      `OFS_STATUS: next_rdata = {20'h0, lastCycles, 7'h0, busy};
      `OFS_ACC: next_rdata = {24'h0, acc};
      `OFS_STATUS_WORD: next_rdata = {24'h0, statusWord};
      `OFS_PC: next_rdata = {16'h0, pc};
      `OFS_SP: next_rdata = {16'h0, sp};
      `OFS_HL: next_rdata = {16'h0, hl};
      `OFS_CLOCK_CONTROL: next_rdata = {29'h0, clockControl};
      `OFS_MEM_ADDR: next_rdata = {16'h0, memAddr};
      `OFS_MEM_DATA: next_rdata = {24'h0, mem[idx(memAddr)]};
      default: begin
        next_rdata = 32'h0000_0000;
        next_rok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rok ? 2'b00 : 2'b10;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule // bit_call_exec

// >>> verification/bit_call_exec_asserts.sv
`timescale 1ns/100ps
module bit_call_exec_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Both halves taken together: held one edge, answer shows the next
  a_b_after_take: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_b_holds: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_b_release: assert property (
    bvalid && bready |=> !bvalid ##0 (awready && wready))
    else $error("write not released");
  a_r_prompt: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_r_holds: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_r_release: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read not released");
  a_ar_blocked: assert property (
    rvalid |-> !arready)
    else $error("read taken while answering");
  a_resp_legal: assert property (
    bvalid |-> bresp == 2'b00 || bresp == 2'b10)
    else $error("bad write response code");
endmodule // bit_call_exec_asserts
bind bit_call_exec bit_call_exec_asserts u_chk (.clk(clk), .rstn(rstn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready));

// >>> verification/bit_call_exec_tb.sv
`timescale 1ns/100ps
module bit_call_exec_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [33:0] expR[$], mskR[$];
  logic [1:0] expB[$];
  logic [7:0] a, e;
  logic [2:0] b;
  logic lo, hi;
  int fails = 0, nChecks = 0, seed = 38, o;

  initial forever #12.5 clk = ~clk;

  bit_call_exec u_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic summarize();
    $display("fails=%0d checks=%0d", fails, nChecks);
    if (fails == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic bad(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic checkRd(input logic [33:0] got);
    logic [33:0] x, m;
    x = expR.pop_front();
    m = mskR.pop_front();
    nChecks++;
    if (((got ^ x) & m) !== 34'h0) bad("read value");
  endtask

  task automatic checkWr(input logic [1:0] got);
    nChecks++;
    if (got !== expB.pop_front()) bad("write response");
  endtask

  // Results are judged apart from the driver, oldest note first
  always @(posedge clk) begin
    if (rvalid && rready) checkRd({rresp, rdata});
    if (bvalid && bready) checkWr(bresp);
  end

  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] r);
    expB.push_back(r);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [33:0] x,
                    input logic [33:0] m);
    expR.push_back(x);
    mskR.push_back(m);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] ad, input logic [31:0] d);
    rd(ad, {2'b00, d}, {34{1'b1}});
  endtask

  // Only the four live flags are compared
  task automatic flags(input logic [7:0] d);
    rd(8'h10, {26'h0, d}, 34'h0d1);
  endtask

  function automatic logic [31:0] cmd(input logic [3:0] op,
                                      input logic [2:0] k, input logic [2:0] t);
    return {21'h0, k, 1'b0, t, op};
  endfunction

  task automatic exec(input logic [31:0] c, input logic [3:0] n);
    wr(8'h00, c, 2'b00);
    do rd(8'h08, 34'h0, 34'h0); while (v[0] !== 1'b0);
    chk(8'h08, {20'h0, n, 8'h00});
  endtask

  task automatic mset(input logic [15:0] ad, input logic [7:0] d);
    wr(8'h20, {16'h0, ad}, 2'b00);
    wr(8'h24, {24'h0, d}, 2'b00);
  endtask

  task automatic mchk(input logic [15:0] ad, input logic [7:0] d);
    wr(8'h20, {16'h0, ad}, 2'b00);
    chk(8'h24, {24'h0, d});
  endtask

  initial begin
    #(25 * 30000);
    bad("timeout");
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    chk(8'h0c, 32'h0);
    chk(8'h10, 32'h2);
    chk(8'h14, 32'h0);
    chk(8'h18, 32'hfee0);
    chk(8'h1c, 32'h0);
    rd(8'h30, {2'b10, 32'h0}, {34{1'b1}});
    for (int i = 0; i < 20; i++) begin
      a = $random(seed);
      e = $random(seed) & 8'hd1;
      b = $random(seed);
      o = i % 5;
      wr(8'h0c, {24'h0, a}, 2'b00);
      wr(8'h10, {24'h0, e}, 2'b00);
      exec(cmd((o == 4) ? 4'h7 : o[3:0], 3'h2, b), 4'h4);
      case (o)
        0: e[0] = e[0] & a[b];
        1: e[0] = e[0] | a[b];
        2: e[0] = e[0] ^ a[b];
        3: e[0] = a[b];
        default: begin
          lo = e[4] || a[3:0] > 4'h9;
          hi = e[0] || a > 8'h99;
          a = a - (lo ? 8'h06 : 8'h00) - (hi ? 8'h60 : 8'h00);
          e[0] = hi;
          e[4] = lo;
          e[6] = (a == 8'h00);
        end
      endcase
      flags(e);
      chk(8'h0c, {24'h0, a});
    end
    // Same memory byte reached through fast and slow aliases
    mset(16'hfe25, 8'h80);
    wr(8'h10, 32'h0, 2'b00);
    wr(8'h04, 32'hfe25, 2'b00);
    exec(cmd(4'h2, 3'h0, 3'h7), 4'h6);
    flags(8'h01);
    wr(8'h04, 32'h0025, 2'b00);
    exec(cmd(4'h2, 3'h0, 3'h7), 4'h7);
    flags(8'h00);
    wr(8'h28, 32'hfe25, 2'b00);
    exec(cmd(4'h0, 3'h4, 3'h7), 4'h6);
    exec(cmd(4'h5, 3'h3, 3'h6), 4'h6);
    exec(cmd(4'h6, 3'h3, 3'h4), 4'h6);
    flags(8'h40);
    // Store carry into a special-register bit: long count
    wr(8'h10, 32'h01, 2'b00);
    wr(8'h04, 32'h0025, 2'b00);
    exec(cmd(4'h4, 3'h1, 3'h0), 4'h8);
    mchk(16'h0025, 8'h81);
    wr(8'h10, 32'h40, 2'b00);
    wr(8'h14, 32'h1234, 2'b00);
    wr(8'h04, 32'habcd, 2'b00);
    exec(cmd(4'h8, 3'h0, 3'h0), 4'h7);
    chk(8'h14, 32'habcd);
    chk(8'h18, 32'hfede);
    mchk(16'hfedf, 8'h12);
    mchk(16'hfede, 8'h37);
    exec(cmd(4'hc, 3'h0, 3'h0), 4'h6);
    chk(8'h14, 32'h1237);
    chk(8'h18, 32'hfee0);
    flags(8'h40);
    wr(8'h04, 32'h07a5, 2'b00);
    exec(cmd(4'h9, 3'h0, 3'h0), 4'h5);
    chk(8'h14, 32'h0fa5);
    mchk(16'hfede, 8'h39);
    mset(16'h0040, 8'h56);
    mset(16'h0041, 8'h34);
    wr(8'h04, 32'h0040, 2'b00);
    exec(cmd(4'ha, 3'h0, 3'h0), 4'h6);
    chk(8'h14, 32'h3456);
    chk(8'h18, 32'hfedc);
    mchk(16'hfedd, 8'h0f);
    mchk(16'hfedc, 8'ha6);
    mset(16'h003e, 8'h78);
    mset(16'h003f, 8'h9a);
    // Both frame returns undo the same break frame
    for (int r = 0; r < 2; r++) begin
      wr(8'h14, 32'h3456, 2'b00);
      wr(8'h10, 32'h83, 2'b00);
      exec(cmd(4'hb, 3'h0, 3'h0), 4'h6);
      mchk(16'hfedb, 8'h83);
      mchk(16'hfeda, 8'h34);
      mchk(16'hfed9, 8'h57);
      chk(8'h14, 32'h9a78);
      chk(8'h18, 32'hfed9);
      flags(8'h01);
      exec(cmd(r ? 4'he : 4'hd, 3'h0, 3'h0), 4'h6);
      chk(8'h14, 32'h3457);
      chk(8'h18, 32'hfedc);
      flags(8'h81);
    end
    // Slow CPU clock keeps the block busy long enough to collide
    wr(8'h1c, 32'h2, 2'b00);
    wr(8'h00, cmd(4'h7, 3'h0, 3'h0), 2'b00);
    wr(8'h0c, 32'h55, 2'b10);
    wr(8'h20, 32'h0041, 2'b00);
    do rd(8'h08, 34'h0, 34'h0); while (v[0] !== 1'b0);
    chk(8'h08, 32'h400);
    chk(8'h20, 32'h41);
    wr(8'h00, 32'h0000000f, 2'b10);
    wr(8'h30, 32'h0, 2'b10);
    summarize();
  end
endmodule // bit_call_exec_tb
